// ### hdl/sisb_pkg.sv
// sisb_pkg: constants for the sense and identification status bank.
// assumes 24-bit register words addressed by a 6-bit register index.
package sisb_pkg;
    localparam int unsigned SISB_DATA_W = 24;
    localparam int unsigned SISB_ADDR_W = 6;
    localparam int unsigned SISB_SYNC_STAGES = 2;

    // register indices
    localparam logic [5:0] SISB_EVENT_SENSE_IDX = 6'h05;
    localparam logic [5:0] SISB_PWRUP_MODE_IDX = 6'h06;
    localparam logic [5:0] SISB_CHIP_ID_IDX = 6'h07;
    localparam logic [5:0] SISB_UNUSED_IDX = 6'h08;

    // event sense word bit positions
    localparam int unsigned SISB_BTN3_BIT = 2;
    localparam int unsigned SISB_BTN1_BIT = 3;
    localparam int unsigned SISB_BTN2_BIT = 4;
    localparam int unsigned SISB_LPB_BIT = 11;
    localparam int unsigned SISB_THLO_BIT = 12;
    localparam int unsigned SISB_THHI_BIT = 13;
    localparam int unsigned SISB_CLKSRC_BIT = 14;
    localparam int unsigned SISB_BATTRM_BIT = 22;

    // power-up mode word bit positions
    localparam int unsigned SISB_MODE0_BIT = 0;
    localparam int unsigned SISB_MODE1_BIT = 1;
    localparam int unsigned SISB_SEL1_BIT = 2;
    localparam int unsigned SISB_PWRST_BIT = 3;
    localparam int unsigned SISB_SEL2_BIT = 4;
    localparam int unsigned SISB_SLOWCLK_BIT = 5;
    localparam int unsigned SISB_CHGPATH_BIT = 9;
    localparam int unsigned SISB_WALLCHG_BIT = 10;

    // identification word field positions
    localparam int unsigned SISB_REV_LSB = 0;
    localparam int unsigned SISB_GEN_LSB = 6;
    localparam int unsigned SISB_FIN_LSB = 9;
    localparam int unsigned SISB_FAB_LSB = 11;
    localparam int unsigned SISB_PART_LSB = 13;

    // value after reset of the read data port
    localparam logic [23:0] SISB_RDATA_RESET = 24'h00_0000;
endpackage

// ### hdl/sisb_sync.sv
// sisb_sync: two-flop synchroniser for a vector of asynchronous levels.
// assumes inputs are quasi-static levels from analog detectors.
`timescale 1ns/100ps
module sisb_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sisb_sync_s;

    sisb_sync_s st;
    sisb_sync_s next_st;

    // elaboration check: an empty vector cannot be synchronised
    if (WIDTH < 1) begin : g_bad_width
        $error("sisb_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_comb begin
        next_st = st;
        next_st.meta = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule

// ### hdl/sisb_bank.sv
// sisb_bank: read-only sense, power-up mode and identification words.
// assumes a serial control port front end presents a register index,
// a read strobe and a write strobe, all on clk_sys.
//
// Operation
// (R1) low-power boot sense at event bit 11
// (R2) battery removed sense live at bit 22
// (R3) charger path config latched at bit 9
// (R4) charger path bit refreshed only on enable
// (R5) register 6 holds mode decode, pin states
// (R6) register 7 revision, generation, fin, fab fields
// (R7) part code bits 13-18, upper bits zero
// (R8) register 8 reads all zero
// (R9) writes to these words are ignored
`timescale 1ns/100ps
module sisb_bank
    import sisb_pkg::*;
#(
    parameter logic [4:0] REVISION = 5'h01, // arbitrary value
    parameter logic [2:0] GENERATION = 3'h2, // arbitrary value
    parameter logic [1:0] FIN = 2'h0, // arbitrary value
    parameter logic [1:0] FAB = 2'h0, // arbitrary value
    parameter logic [5:0] PART_CODE = 6'h05 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [sisb_pkg::SISB_ADDR_W-1:0] reg_index,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [sisb_pkg::SISB_DATA_W-1:0] reg_wdata,
    output logic [sisb_pkg::SISB_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic button1_sense,
    input wire logic button2_sense,
    input wire logic button3_sense,
    input wire logic lowpower_boot_sense,
    input wire logic thermal_low_sense,
    input wire logic thermal_high_sense,
    input wire logic clock_source_sense,
    input wire logic battery_removed_sense,
    input wire logic mode_decode_bit0,
    input wire logic mode_decode_bit1,
    input wire logic select1_state,
    input wire logic power_state_bit,
    input wire logic select2_state,
    input wire logic slow_clock_forced_on_state,
    input wire logic charger_path_config_sense,
    input wire logic wall_charger_sense,
    input wire logic charger_enabled
);
    import sisb_pkg::*;

    localparam int unsigned NSENSE = 17;

    typedef struct packed {
        logic [SISB_DATA_W-1:0] rdata;
        logic rvalid;
        logic chg_en_prev;
        logic chgpath_latched;
    } sisb_bank_s;

    sisb_bank_s st;
    sisb_bank_s next_st;
    logic [NSENSE-1:0] raw_in;
    logic [NSENSE-1:0] s;
    logic [SISB_DATA_W-1:0] event_word;
    logic [SISB_DATA_W-1:0] mode_word;
    logic [SISB_DATA_W-1:0] id_word;
    logic chg_en_rise;

    // elaboration checks: the word layout, the register index width and
    // the two-flop synchroniser are built into the logic below
    if (SISB_DATA_W != 24) begin : g_bad_width
        $error("sisb_bank: register words must be 24 bits");
    end
    if (SISB_ADDR_W != 6) begin : g_bad_index
        $error("sisb_bank: register index must be 6 bits");
    end
    if (SISB_SYNC_STAGES != 2) begin : g_bad_sync
        $error("sisb_bank: synchroniser must have two stages");
    end

    // place a single bit at a position in a register word
    function automatic logic [SISB_DATA_W-1:0] put_bit(
        input logic v,
        input int unsigned pos
    );
        logic [SISB_DATA_W-1:0] w;
        w = '0;
        w[pos] = v;
        return w;
    endfunction

    // gather the detector levels for synchronising
    // the bit order here fixes the s[] indices used below
    assign raw_in = {charger_enabled, wall_charger_sense,
        charger_path_config_sense, slow_clock_forced_on_state,
        select2_state, power_state_bit, select1_state,
        mode_decode_bit1, mode_decode_bit0, battery_removed_sense,
        clock_source_sense, thermal_high_sense, thermal_low_sense,
        lowpower_boot_sense, button3_sense, button2_sense,
        button1_sense};

    // every detector level crosses into clk_sys through two flops
    sisb_sync #(
        .WIDTH(NSENSE)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(raw_in),
        .sync_out(s)
    );

    // charger enable edge: enable and path sense pass the same two flops,
    // so the path value seen at the edge is the one that stood as the
    // charger came on
    assign chg_en_rise = s[16] & ~st.chg_en_prev;

    // event sense word: live levels, unused bits zero
    always_comb begin
        event_word = put_bit(s[2], SISB_BTN3_BIT)
            | put_bit(s[0], SISB_BTN1_BIT)
            | put_bit(s[1], SISB_BTN2_BIT)
            | put_bit(s[3], SISB_LPB_BIT) // see (R1)
            | put_bit(s[4], SISB_THLO_BIT)
            | put_bit(s[5], SISB_THHI_BIT)
            | put_bit(s[6], SISB_CLKSRC_BIT)
            | put_bit(s[7], SISB_BATTRM_BIT); // see (R2)
    end

    // power-up mode word: decode, pin states, latched charger path
    always_comb begin
        mode_word = put_bit(s[8], SISB_MODE0_BIT) // see (R5)
            | put_bit(s[9], SISB_MODE1_BIT)
            | put_bit(s[10], SISB_SEL1_BIT)
            | put_bit(s[11], SISB_PWRST_BIT)
            | put_bit(s[12], SISB_SEL2_BIT)
            | put_bit(s[13], SISB_SLOWCLK_BIT)
            | put_bit(st.chgpath_latched, SISB_CHGPATH_BIT) // see (R3)
            | put_bit(s[15], SISB_WALLCHG_BIT);
    end

    // identification word from fixed codes, bits 19-23 zero
    always_comb begin
        id_word = '0;
        id_word[SISB_REV_LSB +: 5] = REVISION; // see (R6)
        id_word[SISB_GEN_LSB +: 3] = GENERATION;
        id_word[SISB_FIN_LSB +: 2] = FIN;
        id_word[SISB_FAB_LSB +: 2] = FAB;
        id_word[SISB_PART_LSB +: 6] = PART_CODE; // see (R7)
    end

    // next state: read mux, charger path latch
    // rdata holds between reads so a slow host may fetch it late;
    // rvalid is a one-cycle marker of a fresh answer
    always_comb begin
        next_st = st;
        next_st.chg_en_prev = s[16];
        next_st.rvalid = reg_read;
        if (chg_en_rise) begin
            next_st.chgpath_latched = s[14]; // see (R4)
        end
        // writes never reach any field of these words, see (R9)
        if (reg_read) begin
            case (reg_index)
                SISB_EVENT_SENSE_IDX: next_st.rdata = event_word;
                SISB_PWRUP_MODE_IDX: next_st.rdata = mode_word;
                SISB_CHIP_ID_IDX: next_st.rdata = id_word;
                SISB_UNUSED_IDX: next_st.rdata = '0; // see (R8)
                default: next_st.rdata = '0;
            endcase
        end
    end

    // state register; the read port, the enable history and the charger latch all reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st.rdata <= SISB_RDATA_RESET;
            st.rvalid <= 1'b0;
            st.chg_en_prev <= 1'b0;
            st.chgpath_latched <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs come straight from the state register
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;

    // assertions: a read taken at one edge is answered at the next, so
    // each sense check holds the answer against the levels sampled one edge back

    // low-power boot sense appears live in the event word
    a_lpb_follows: assert property ( // see (R1)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_EVENT_SENSE_IDX |=>
        reg_rdata[SISB_LPB_BIT] == $past(s[3]))
        else $error("low-power boot bit does not follow sense");

    // battery removal sense appears live in the event word
    a_batt_follows: assert property ( // see (R2)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_EVENT_SENSE_IDX |=>
        reg_rdata[SISB_BATTRM_BIT] == $past(s[7]))
        else $error("battery removed bit does not follow sense");

    // button levels sit at bits 2 to 4 of the event word
    a_buttons_follow: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_EVENT_SENSE_IDX |=>
        reg_rdata[4:2] == {$past(s[1]), $past(s[0]), $past(s[2])})
        else $error("button sense bits wrong");

    // thermal and clock source levels sit at bits 12 to 14
    a_thermal_follow: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_EVENT_SENSE_IDX |=>
        reg_rdata[14:12] == $past(s[6:4]))
        else $error("thermal or clock source bits wrong");

    // event bits with no detector behind them read zero
    a_event_spare: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_EVENT_SENSE_IDX |=>
        reg_rdata[1:0] == 2'h0 && reg_rdata[10:5] == 6'h00 &&
        reg_rdata[21:15] == 7'h00 && !reg_rdata[23])
        else $error("unused event bits not zero");

    // the latched charger path shows at its bit of the mode word
    a_chgpath_shown: assert property ( // see (R3)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_PWRUP_MODE_IDX |=>
        reg_rdata[SISB_CHGPATH_BIT] == $past(st.chgpath_latched))
        else $error("charger path bit not shown");

    // the latch only moves on a charger enable edge
    a_chgpath_hold: assert property ( // see (R4)
        @(posedge clk_sys) disable iff (rst)
        !chg_en_rise |=> $stable(st.chgpath_latched))
        else $error("charger path bit changed without enable");

    // on an enable edge the latch takes the present path sense
    a_chgpath_latch: assert property ( // see (R4)
        @(posedge clk_sys) disable iff (rst)
        chg_en_rise |=> st.chgpath_latched == $past(s[14]))
        else $error("charger path bit not refreshed on enable");

    // mode decode and power-up pin states in the low bits
    a_mode_pins: assert property ( // see (R5)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_PWRUP_MODE_IDX |=>
        reg_rdata[5:0] == $past(s[13:8]) &&
        reg_rdata[8:6] == 3'h0)
        else $error("mode word pin fields wrong");

    // wall charger sense at bit 10, everything above it zero
    a_mode_upper: assert property ( // see (R5)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_PWRUP_MODE_IDX |=>
        reg_rdata[10] == $past(s[15]) && reg_rdata[23:11] == 13'h0000)
        else $error("mode word upper bits wrong");

    // revision, generation, fin and fab fields
    a_id_fields: assert property ( // see (R6)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_CHIP_ID_IDX |=>
        reg_rdata[12:0] == {FAB, FIN, GENERATION, 1'b0, REVISION})
        else $error("identification fields wrong");

    // part code and zero upper bits
    a_id_code: assert property ( // see (R7)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_CHIP_ID_IDX |=>
        reg_rdata[23:13] == {5'h00, PART_CODE})
        else $error("part code or upper bits wrong");

    // the unused word answers with zero
    a_unused_zero: assert property ( // see (R8)
        @(posedge clk_sys) disable iff (rst)
        reg_read && reg_index == SISB_UNUSED_IDX |=>
        reg_rdata == 24'h00_0000 && reg_rvalid)
        else $error("unused word not zero");

    // indices outside the bank answer with zero
    a_unmapped_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_read && (reg_index < SISB_EVENT_SENSE_IDX ||
        reg_index > SISB_UNUSED_IDX) |=> reg_rdata == 24'h00_0000)
        else $error("unmapped index not zero");

    // every read is answered at the next edge
    a_read_answer: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_read |=> reg_rvalid)
        else $error("read not answered in one cycle");

    // the valid marker drops after any cycle without a read
    a_rvalid_drop: assert property (
        @(posedge clk_sys) disable iff (rst)
        !reg_read |=> !reg_rvalid)
        else $error("read valid without a read");

    // a write leaves the read data alone
    a_write_ignored: assert property ( // see (R9)
        @(posedge clk_sys) disable iff (rst)
        reg_write && !reg_read |=> $stable(reg_rdata))
        else $error("write disturbed read data");

    // a write draws no answer
    a_write_silent: assert property ( // see (R9)
        @(posedge clk_sys) disable iff (rst)
        reg_write && !reg_read |=> !reg_rvalid)
        else $error("write produced a read valid");
endmodule

// ### test/sisb_host.sv
// sisb_host: host model that reads and writes the bank's words.
// assumes a one-cycle read strobe and a registered read valid answer.
`timescale 1ns/100ps
module sisb_host
    import sisb_pkg::*;
(
    input wire logic clk_sys,
    output logic [sisb_pkg::SISB_ADDR_W-1:0] reg_index,
    output logic reg_read,
    output logic reg_write,
    output logic [sisb_pkg::SISB_DATA_W-1:0] reg_wdata,
    input wire logic [sisb_pkg::SISB_DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus from time zero
    initial begin
        reg_index = 6'h00;
        reg_read = 1'b0;
        reg_write = 1'b0;
        reg_wdata = 24'h00_0000;
    end

    // one read strobe; the answer is taken at the next edge only
    task automatic rd(input logic [5:0] idx, output logic [23:0] data);
        data = 'x;
        @(posedge clk_sys);
        reg_index <= idx;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        reg_index <= ~idx; // released index stops showing the last value
        @(posedge clk_sys);
        if (reg_rvalid === 1'b1) begin
            data = reg_rdata;
        end
    endtask

    // one write strobe; the bank is expected to ignore it
    task automatic wr(input logic [5:0] idx, input logic [23:0] data);
        @(posedge clk_sys);
        reg_index <= idx;
        reg_wdata <= data;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_wdata <= ~data;
    endtask
endmodule

// ### test/tb_top.sv
// tb_top: self-checking bench for the sense and identification bank.
// assumes the bank answers reads one cycle after the strobe edge.
`timescale 1ns/100ps
module tb_top;
    import sisb_pkg::*;
    localparam logic [4:0] REV = 5'h0a; // arbitrary value
    localparam logic [2:0] GEN = 3'h5; // arbitrary value
    localparam logic [1:0] FIN = 2'h2; // arbitrary value
    localparam logic [1:0] FAB = 2'h1; // arbitrary value
    localparam logic [5:0] PC = 6'h2b; // arbitrary value
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [16:0] s = 17'h0_0000;
    logic [5:0] reg_index;
    logic reg_read;
    logic reg_write;
    logic [23:0] reg_wdata;
    logic [23:0] reg_rdata;
    logic reg_rvalid;
    logic [23:0] d;
    int fails = 0;
    int checks = 0;
    int pos [16] = '{3, 4, 2, 11, 12, 13, 14, 22, 0, 1, 2, 3, 4, 5, 9, 10};
    logic [23:0] id_exp;

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    sisb_bank #(.REVISION(REV), .GENERATION(GEN), .FIN(FIN), .FAB(FAB),
        .PART_CODE(PC)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .reg_index(reg_index), .reg_read(reg_read), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .button1_sense(s[0]),
        .button2_sense(s[1]), .button3_sense(s[2]),
        .lowpower_boot_sense(s[3]), .thermal_low_sense(s[4]),
        .thermal_high_sense(s[5]), .clock_source_sense(s[6]),
        .battery_removed_sense(s[7]), .mode_decode_bit0(s[8]),
        .mode_decode_bit1(s[9]), .select1_state(s[10]),
        .power_state_bit(s[11]), .select2_state(s[12]),
        .slow_clock_forced_on_state(s[13]),
        .charger_path_config_sense(s[14]), .wall_charger_sense(s[15]),
        .charger_enabled(s[16]));

    sisb_host u_host (.clk_sys(clk_sys), .reg_index(reg_index),
        .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // compare and count
    task automatic chk(input string nm, input logic [23:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // drive sense levels, then let the synchroniser settle
    task automatic put(input logic [16:0] v);
        @(posedge clk_sys);
        s <= v;
        repeat (4) @(posedge clk_sys);
    endtask

    // one sense input at a time shows at its own bit only
    task automatic t_sense;
        for (int i = 0; i < 16; i++) begin
            if (i == 14) continue;
            put(17'h0_0001 << i);
            u_host.rd(i < 8 ? 6'h05 : 6'h06, d);
            chk("sense bit", 24'h00_0001 << pos[i], d);
        end
        put(17'h0_0000);
        u_host.rd(6'h05, d);
        chk("event idle", 24'h00_0000, d);
        $display("test sense done");
    endtask

    // charger path bit latches only when the charger is enabled
    task automatic t_charger;
        put(17'h0_4000);
        u_host.rd(6'h06, d);
        chk("path before enable", 24'h00_0000, d);
        put(17'h1_4000);
        u_host.rd(6'h06, d);
        chk("path on enable", 24'h00_0200, d);
        put(17'h1_0000);
        u_host.rd(6'h06, d);
        chk("path held", 24'h00_0200, d);
        put(17'h0_0000);
        put(17'h1_0000);
        u_host.rd(6'h06, d);
        chk("path refreshed", 24'h00_0000, d);
        put(17'h0_0000);
        $display("test charger done");
    endtask

    // id fields, unused word, and writes that must change nothing
    task automatic t_id_write;
        id_exp = {5'h00, PC, FAB, FIN, GEN, 1'b0, REV};
        for (int i = 5; i < 9; i++) begin
            u_host.wr(i[5:0], 24'hff_ffff);
        end
        u_host.rd(6'h07, d);
        chk("id word", id_exp, d);
        u_host.rd(6'h08, d);
        chk("unused word", 24'h00_0000, d);
        u_host.rd(6'h06, d);
        chk("mode after write", 24'h00_0000, d);
        u_host.rd(6'h09, d);
        chk("unmapped", 24'h00_0000, d);
        $display("test id and write done");
    endtask

    // print counts and the verdict, then stop
    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_sense();
        t_charger();
        t_id_write();
        finish_test();
    end

    // watchdog well beyond the expected few hundred cycles
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule
